// File: inc/nvm_pkg.sv
// Constants for the byte-wide nonvolatile store access controller.
// Assumes a CPU I/O space with 6-bit addresses and 8-bit data.
package nvm_pkg;
   localparam int unsigned IO_ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned INDEX_W = 6;
   localparam int unsigned DEPTH = 64;
   localparam logic [IO_ADDR_W-1:0] OFS_BYTE_INDEX = 6'h1E;
   localparam logic [IO_ADDR_W-1:0] OFS_BYTE_VALUE = 6'h1D;
   localparam logic [IO_ADDR_W-1:0] OFS_CONTROL = 6'h1C;
   localparam int unsigned BIT_READ_STROBE = 0;
   localparam int unsigned BIT_WRITE_STROBE = 1;
   localparam int unsigned BIT_WRITE_ARM = 2;
   localparam int unsigned BIT_READY_IRQ_EN = 3;
   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [INDEX_W-1:0] RESET_INDEX = 6'h00;
   // Programming length in calibrated oscillator cycles.
   localparam int unsigned PROG_RC_CYCLES = 8192;
   localparam int unsigned PROG_CNT_W = 13;
   localparam logic [PROG_CNT_W-1:0] PROG_LAST =
      PROG_CNT_W'(PROG_RC_CYCLES - 1);
   localparam logic [PROG_CNT_W-1:0] PROG_ZERO = 13'h0000;
   localparam int unsigned CNT_W = 3;
   localparam logic [CNT_W-1:0] ARM_WINDOW_CYC = 3'h4;
   localparam logic [CNT_W-1:0] WRITE_STALL_CYC = 3'h2;
   localparam logic [CNT_W-1:0] READ_STALL_CYC = 3'h4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
endpackage : nvm_pkg

// File: hw/nvm_cell_array.sv
// Storage array of the nonvolatile store, one flip-flop byte per entry.
// Assumes the controller commits at most one byte per cycle.
`timescale 1ns/1ps
module nvm_cell_array
   import nvm_pkg::*;
(
   input wire logic i_core_clk, // core clock
   input wire logic i_wr_en, // commit strobe
   input wire logic [INDEX_W-1:0] i_wr_index, // entry to commit
   input wire logic [DATA_W-1:0] i_wr_data, // byte to commit
   input wire logic [INDEX_W-1:0] i_rd_index, // entry to fetch
   output logic [DATA_W-1:0] o_rd_data // fetched byte
);
   logic [DATA_W-1:0] cell_q [DEPTH];
   logic [DATA_W-1:0] cell_d [DEPTH];

   // Cells keep their content through reset, as a nonvolatile store would.
   for (genvar g = 0; g < DEPTH; g++) begin : g_cell
      always_comb begin
         cell_d[g] = cell_q[g];
         if (i_wr_en && i_wr_index == INDEX_W'(g)) begin
            cell_d[g] = i_wr_data;
         end
      end
      always_ff @(posedge i_core_clk) begin
         cell_q[g] <= cell_d[g];
      end
   end

   assign o_rd_data = cell_q[i_rd_index];
endmodule : nvm_cell_array

// File: hw/nvm_access_ctrl.sv
// Access controller giving the CPU byte reads and writes of a 64-byte
// nonvolatile store through three I/O-space registers.
// Assumes I/O strobes synchronous to i_core_clk and a one-cycle pulse on
// i_rc_tick for each cycle of the calibrated oscillator.
`timescale 1ns/1ps
// Contract
// - Time programming by 8192 oscillator ticks.
// - Write strobe stalls CPU two cycles.
// - Read strobe stalls CPU four cycles.
// - Index bits 5..0; top bits read zero.
// - Value register holds write byte, receives read.
// - Ready request while enabled and strobe zero.
// - Write arm clears after four cycles.
// - Strobe programs only while write arm set.
// - Write strobe stays set until programming ends.
// - Read fetches byte, then clears read strobe.
// - Control bits 7..4 read zero, writes ignored.
// - Registers live in I/O space, index 1E.
module nvm_access_ctrl
   import nvm_pkg::*;
(
   input wire logic i_core_clk, // core clock, 125 MHz
   input wire logic i_srst, // synchronous reset, active high
   input wire logic [IO_ADDR_W-1:0] i_io_addr, // I/O register address
   input wire logic i_io_we, // I/O write strobe
   input wire logic i_io_re, // I/O read strobe
   input wire logic [DATA_W-1:0] i_io_wdata, // I/O write data
   input wire logic i_global_irq_en, // global interrupt flag of CPU
   input wire logic i_rc_tick, // calibrated oscillator tick
   output logic [DATA_W-1:0] o_io_rdata, // I/O read data, registered
   output logic o_cpu_stall, // halts the CPU
   output logic o_ready_irq // ready interrupt request
);
   logic [INDEX_W-1:0] index_q, index_d;
   logic [DATA_W-1:0] value_q, value_d;
   logic irq_en_q, irq_en_d;
   logic arm_q, arm_d;
   logic [CNT_W-1:0] arm_cnt_q, arm_cnt_d;
   logic wstrobe_q, wstrobe_d;
   logic rstrobe_q, rstrobe_d;
   logic [PROG_CNT_W-1:0] prog_cnt_q, prog_cnt_d;
   logic [CNT_W-1:0] stall_cnt_q, stall_cnt_d;
   logic stall_q, stall_d;
   logic irq_q, irq_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic commit;
   logic [DATA_W-1:0] cell_byte;
   logic wr_ctrl, wr_index, wr_value, arm_go, prog_go, rd_go;

   nvm_cell_array u_cells (
      .i_core_clk(i_core_clk),
      .i_wr_en(commit),
      .i_wr_index(index_q),
      .i_wr_data(value_q),
      .i_rd_index(index_q),
      .o_rd_data(cell_byte)
   );

   always_comb begin
      wr_ctrl = i_io_we && i_io_addr == OFS_CONTROL;
      wr_index = i_io_we && i_io_addr == OFS_BYTE_INDEX;
      wr_value = i_io_we && i_io_addr == OFS_BYTE_VALUE;
      arm_go = wr_ctrl && i_io_wdata[BIT_WRITE_ARM] && !wstrobe_q
         && !arm_q;
      prog_go = wr_ctrl && i_io_wdata[BIT_WRITE_STROBE] && arm_q
         && !wstrobe_q;
      rd_go = wr_ctrl && i_io_wdata[BIT_READ_STROBE];
      commit = wstrobe_q && i_rc_tick && prog_cnt_q == PROG_LAST;
   end

   // Register file and access sequencing.
   always_comb begin
      index_d = index_q;
      value_d = value_q;
      irq_en_d = irq_en_q;
      if (wr_index) begin
         index_d = i_io_wdata[INDEX_W-1:0];
      end
      // A write landing during programming corrupts the byte in flight;
      // software is expected to keep its hands off.
      if (wr_value) begin
         value_d = i_io_wdata;
      end else if (rstrobe_q) begin
         value_d = cell_byte;
      end
      if (wr_ctrl) begin
         irq_en_d = i_io_wdata[BIT_READY_IRQ_EN];
      end
      arm_cnt_d = arm_cnt_q;
      if (arm_go) begin
         arm_cnt_d = ARM_WINDOW_CYC;
      end else if (arm_cnt_q != CNT_ZERO) begin
         arm_cnt_d = arm_cnt_q - CNT_ONE;
      end
      arm_d = arm_cnt_d != CNT_ZERO;
      wstrobe_d = wstrobe_q;
      prog_cnt_d = prog_cnt_q;
      if (prog_go) begin
         wstrobe_d = 1'b1;
         prog_cnt_d = PROG_ZERO;
      end else if (commit) begin
         wstrobe_d = 1'b0;
      end else if (wstrobe_q && i_rc_tick) begin
         prog_cnt_d = prog_cnt_q + 13'h0001;
      end
      rstrobe_d = rd_go && !rstrobe_q;
      stall_cnt_d = stall_cnt_q;
      if (rd_go) begin
         stall_cnt_d = READ_STALL_CYC;
      end else if (prog_go) begin
         stall_cnt_d = WRITE_STALL_CYC;
      end else if (stall_cnt_q != CNT_ZERO) begin
         stall_cnt_d = stall_cnt_q - CNT_ONE;
      end
      stall_d = rd_go || prog_go || stall_cnt_q > CNT_ONE;
      irq_d = irq_en_d && i_global_irq_en && !wstrobe_d;
      rdata_d = rdata_q;
      if (i_io_re) begin
         rdata_d = '0;
         case (i_io_addr)
            OFS_BYTE_INDEX: rdata_d[INDEX_W-1:0] = index_q;
            OFS_BYTE_VALUE: rdata_d = value_q;
            OFS_CONTROL: begin
               rdata_d[BIT_READ_STROBE] = rstrobe_q;
               rdata_d[BIT_WRITE_STROBE] = wstrobe_q;
               rdata_d[BIT_WRITE_ARM] = arm_q;
               rdata_d[BIT_READY_IRQ_EN] = irq_en_q;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         index_q <= RESET_INDEX;
         value_q <= RESET_BYTE;
         irq_en_q <= 1'b0;
         arm_q <= 1'b0;
         arm_cnt_q <= CNT_ZERO;
         wstrobe_q <= 1'b0;
         rstrobe_q <= 1'b0;
         prog_cnt_q <= PROG_ZERO;
         stall_cnt_q <= CNT_ZERO;
         stall_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= RESET_BYTE;
      end else begin
         index_q <= index_d;
         value_q <= value_d;
         irq_en_q <= irq_en_d;
         arm_q <= arm_d;
         arm_cnt_q <= arm_cnt_d;
         wstrobe_q <= wstrobe_d;
         rstrobe_q <= rstrobe_d;
         prog_cnt_q <= prog_cnt_d;
         stall_cnt_q <= stall_cnt_d;
         stall_q <= stall_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_io_rdata = rdata_q;
   assign o_cpu_stall = stall_q;
   assign o_ready_irq = irq_q;

   a_arm_window:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      arm_go |=> arm_q [*4] ##1 !arm_q)
   else $error("write arm not held for exactly four cycles");

   a_write_stall:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (prog_go && !rd_go) |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
   else $error("write stall length wrong");

   a_read_stall:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (rd_go && !prog_go && stall_cnt_q == CNT_ZERO)
      |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
   else $error("read stall length wrong");

   a_no_arm_no_prog:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (wr_ctrl && i_io_wdata[BIT_WRITE_STROBE] && !arm_q && !wstrobe_q)
      |=> !wstrobe_q)
   else $error("programming started without write arm");

   a_prog_holds:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (wstrobe_q && !(i_rc_tick && prog_cnt_q == PROG_LAST)) |=> wstrobe_q)
   else $error("write strobe dropped before programming end");

   a_prog_ends:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (wstrobe_q && i_rc_tick && prog_cnt_q == PROG_LAST)
      |=> !wstrobe_q && u_cells.cell_q[$past(index_q)] == $past(value_q))
   else $error("programming did not end or commit on last tick");

   a_read_fetch:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (rd_go && !rstrobe_q && !wr_value) |=> rstrobe_q ##1
      (!rstrobe_q && value_q == $past(cell_byte)))
   else $error("read strobe did not fetch the indexed byte");

   a_ready_irq:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      wstrobe_q |-> !o_ready_irq)
   else $error("ready request raised during programming");

   a_irq_follows:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (irq_en_q && i_global_irq_en && !wstrobe_q) [*2] |-> o_ready_irq)
   else $error("ready request missing while idle and enabled");

   a_reserved_zero:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_io_re && (i_io_addr == OFS_CONTROL || i_io_addr == OFS_BYTE_INDEX))
      |=> o_io_rdata[7:6] == 2'h0 && (o_io_rdata[7:4] == 4'h0
      || $past(i_io_addr) == OFS_BYTE_INDEX))
   else $error("reserved bits read non-zero");

   a_busy_no_arm:
   assert property (@(posedge i_core_clk) disable iff (i_srst)
      (wstrobe_q && !arm_q) |=> !arm_q)
   else $error("write arm taken during programming");
endmodule : nvm_access_ctrl

// File: tb/nvm_cpu_model.sv
// CPU core model issuing I/O register reads and writes to the controller.
// Assumes requests are sampled on the rising edge of i_core_clk.
`timescale 1ns/1ps
module nvm_cpu_model
   import nvm_pkg::*;
(
   input wire logic i_core_clk, // core clock
   input wire logic [DATA_W-1:0] i_io_rdata, // read data
   input wire logic i_cpu_stall, // halt request
   output logic [IO_ADDR_W-1:0] o_io_addr, // I/O address
   output logic o_io_we, // write pulse
   output logic o_io_re, // read pulse
   output logic [DATA_W-1:0] o_io_wdata, // write data
   output logic o_gie // global interrupt flag
);
   initial begin
      o_io_addr = 6'h00;
      o_io_we = 1'b0;
      o_io_re = 1'b0;
      o_io_wdata = 8'h00;
      o_gie = 1'b0;
   end

   // Ends a run of back-to-back requests. Call it only when a clock edge
   // follows, never just ahead of a new request in the same time step.
   task automatic io_idle();
      o_io_we = 1'b0;
      o_io_re = 1'b0;
      // Released data is inverted so a stale byte is never mistaken.
      o_io_wdata = ~o_io_wdata;
   endtask : io_idle

   task automatic set_gie(input logic g);
      o_gie = g;
   endtask : set_gie

   // A halted core issues nothing, so drop any held request and wait.
   task automatic hold_off();
      if (i_cpu_stall === 1'b1) begin
         io_idle();
      end
      while (i_cpu_stall === 1'b1) begin
         @(posedge i_core_clk);
         #1;
      end
   endtask : hold_off

   // Requests stay up after the taking edge, so a following call replaces
   // them without toggling a strobe twice in one time step.
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      hold_off();
      o_io_addr = a;
      o_io_wdata = d;
      o_io_re = 1'b0;
      o_io_we = 1'b1;
      @(posedge i_core_clk);
      #1;
   endtask : io_wr

   task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
      hold_off();
      o_io_addr = a;
      o_io_we = 1'b0;
      o_io_re = 1'b1;
      @(posedge i_core_clk);
      #1;
      d = i_io_rdata;
   endtask : io_rd
endmodule : nvm_cpu_model

// File: tb/test_eeprom_access_controller.sv
// Self-checking bench for the nonvolatile store access controller.
// Assumes the oscillator tick may pulse every other core clock cycle.
`timescale 1ns/1ps
module test_eeprom_access_controller;
   import nvm_pkg::*;
   logic clk, srst, tick, we, re, stall, irq, gie;
   logic [IO_ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, v;
   int fail_count = 0, compares = 0, cycles = 0, t0, k;

   nvm_cpu_model nvm_cpu_model_i (.i_core_clk(clk), .i_io_rdata(rdata),
      .i_cpu_stall(stall), .o_io_addr(addr), .o_io_we(we), .o_io_re(re),
      .o_io_wdata(wdata), .o_gie(gie));
   nvm_access_ctrl nvm_access_ctrl_i (.i_core_clk(clk), .i_srst(srst),
      .i_io_addr(addr), .i_io_we(we), .i_io_re(re), .i_io_wdata(wdata),
      .i_global_irq_en(gie), .i_rc_tick(tick), .o_io_rdata(rdata),
      .o_cpu_stall(stall), .o_ready_irq(irq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial tick = 1'b0;
   always @(posedge clk) tick <= ~tick;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      nvm_cpu_model_i.io_wr(a, d);
   endtask : wr

   task automatic rd_chk(input string what, input logic [5:0] a,
                         input logic [7:0] exp);
      nvm_cpu_model_i.io_rd(a, v);
      check(what, {8'h00, v}, {8'h00, exp});
   endtask : rd_chk

   task automatic count_stall();
      nvm_cpu_model_i.io_idle();
      k = 0;
      repeat (8) begin
         if (stall === 1'b1) k++;
         @(posedge clk);
         #1;
      end
   endtask : count_stall

   task automatic t_regs();
      wr(OFS_BYTE_INDEX, 8'hFF);
      rd_chk("index", OFS_BYTE_INDEX, 8'h3F);
      wr(OFS_CONTROL, 8'hF0);
      rd_chk("control", OFS_CONTROL, 8'h00);
      rd_chk("unmapped", 6'h00, 8'h00);
      wr(OFS_CONTROL, 8'hF8);
      rd_chk("control", OFS_CONTROL, 8'h08);
      nvm_cpu_model_i.set_gie(1'b1);
      repeat (3) @(posedge clk);
      #1;
      check("irq on", irq, 1'b1);
      nvm_cpu_model_i.set_gie(1'b0);
      repeat (3) @(posedge clk);
      #1;
      check("irq masked", irq, 1'b0);
   endtask : t_regs

   task automatic t_arm();
      wr(OFS_CONTROL, 8'h0C);
      rd_chk("arm set", OFS_CONTROL, 8'h0C);
      repeat (6) @(posedge clk);
      #1;
      rd_chk("arm expired", OFS_CONTROL, 8'h08);
      wr(OFS_CONTROL, 8'h0A);
      rd_chk("strobe unarmed", OFS_CONTROL, 8'h08);
   endtask : t_arm

   task automatic t_write();
      wr(OFS_BYTE_INDEX, 8'h3F);
      wr(OFS_BYTE_VALUE, 8'hA5);
      wr(OFS_CONTROL, 8'h0C);
      wr(OFS_CONTROL, 8'h0E);
      t0 = cycles;
      count_stall();
      check("write stall", 16'(k), 16'd2);
      rd_chk("busy", OFS_CONTROL, 8'h0A);
      nvm_cpu_model_i.set_gie(1'b1);
      repeat (2) @(posedge clk);
      #1;
      check("irq busy", irq, 1'b0);
      wr(OFS_CONTROL, 8'h0C);
      rd_chk("arm refused", OFS_CONTROL, 8'h0A);
      v = 8'h02;
      while (v[1] === 1'b1 && cycles - t0 < 20000) begin
         nvm_cpu_model_i.io_rd(OFS_CONTROL, v);
      end
      k = cycles - t0;
      check("duration ok", 16'(k >= 16370 && k <= 16400), 16'h1);
      repeat (2) @(posedge clk);
      #1;
      check("irq ready", irq, 1'b1);
   endtask : t_write

   task automatic t_read();
      wr(OFS_BYTE_VALUE, 8'h00);
      rd_chk("value", OFS_BYTE_VALUE, 8'h00);
      wr(OFS_BYTE_INDEX, 8'h3F);
      wr(OFS_CONTROL, 8'h09);
      count_stall();
      check("read stall", 16'(k), 16'd4);
      rd_chk("fetched", OFS_BYTE_VALUE, 8'hA5);
      rd_chk("read done", OFS_CONTROL, 8'h08);
   endtask : t_read

   task automatic stop_test();
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   initial begin
      srst = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      srst = 1'b0;
      t_regs();
      t_arm();
      t_write();
      t_read();
      stop_test();
   end
endmodule : test_eeprom_access_controller
